/* File: verilog/sle_pkg.sv */
// How it works
// (RULE_01) Remote loop one green: sync, clean, margin ok
// (RULE_02) Remote loop one red otherwise
// (RULE_03) Loop two follows the same green/red test
// (RULE_04) Central unit loop lamp green needs both loops
// (RULE_05) T1 lamp green if present and clean
// (RULE_06) Alarm off, red local loss, yellow remote
// (RULE_07) Receive alarm red: framed loss-of-frame, unframed LOS; the code keeps it dark on the remote unit
// (RULE_08) Framing lamp: off unframed, yellow ESF, green SF
// (RULE_09) Line code lamp: yellow B8ZS, green AMI
// (RULE_10) Loopback lamp yellow when any local loopback
// (RULE_11) Remote lamp green for central span loopback; the code does so only on the remote unit with no local loopback
// (RULE_12) Customer loopback at central sends all-ones AIS
// (RULE_13) Local T1 loss outranks remote loss
package sle_pkg;

  // Lamp colour code on a two-bit lamp port
  typedef enum logic [1:0] {
    SLE_OFF,
    SLE_GREEN,
    SLE_RED,
    SLE_YELLOW
  } sle_color_t;

  // Provisioned framing
  typedef enum logic [1:0] {
    SLE_UNFRAMED,
    SLE_ESF,
    SLE_SF
  } sle_frame_t;

  // Margin in quarter dB steps
  localparam int SLE_MARGIN_W = 8;
  localparam logic [7:0] SLE_MARGIN_MIN_DB = 8'h03;
  localparam logic [7:0] SLE_MARGIN_MIN_Q = 8'h0c;

  // All-ones indication byte sent toward the network
  localparam logic [7:0] SLE_AIS_BYTE = 8'hff;
  localparam logic [1:0] SLE_LAMP_RST = 2'h0;

endpackage

/* File: verilog/sle_loop_judge.sv */
`timescale 1ns/100ps
// Judges one loop: healthy only with sync, no errors and enough margin
module sle_loop_judge
  import sle_pkg::*;
(
  // Loop state
  input wire logic sync,
  input wire logic errored,
  input wire logic [SLE_MARGIN_W-1:0] margin_q,
  // Verdict
  output logic healthy
);

  logic margin_ok;

  assign margin_ok = (margin_q >= SLE_MARGIN_MIN_Q); // see RULE_01

  always_comb begin
    healthy = sync && !errored && margin_ok; // see RULE_01
  end

endmodule // sle_loop_judge

/* File: verilog/sle_span_status_led.sv */
`timescale 1ns/100ps
// Front panel lamp encoder for either end of the span
module sle_span_status_led
  import sle_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Unit role: high on the central-office unit
  input wire logic is_central,
  // Loop receivers
  input wire logic loop1_sync,
  input wire logic loop1_err,
  input wire logic [SLE_MARGIN_W-1:0] loop1_margin,
  input wire logic loop2_sync,
  input wire logic loop2_err,
  input wire logic [SLE_MARGIN_W-1:0] loop2_margin,
  // T1 interface monitor
  input wire logic t1_present,
  input wire logic t1_err,
  input wire logic t1_frame_loss,
  input wire logic t1_remote_loss,
  // Provisioning
  input wire logic [1:0] framing_mode,
  input wire logic b8zs_mode,
  // Loopback state
  input wire logic net_loopback,
  input wire logic cust_loopback,
  input wire logic central_span_loopback,
  // Lamps
  output logic [1:0] loop_one_led,
  output logic [1:0] loop_two_led,
  output logic [1:0] t1_signal_led,
  output logic [1:0] alarm_led,
  output logic [1:0] rx_alarm_led,
  output logic [1:0] framing_led,
  output logic [1:0] line_code_led,
  output logic [1:0] remote_loopback_led,
  // Toward the network: force all-ones while customer loopback holds on the central unit
  output logic send_ais
);

  ////////////////////////////////////////////////////////////////////////////
  logic loop1_ok;
  logic loop2_ok;
  logic span_ok;
  logic framed;
  logic rx_loss;
  logic local_held;
  logic far_held;

  ////////////////////////////////////////////////////////////////////////////
  // Colour decoders; each lamp's priority order lives in one place
  // Green for a passing verdict, red for anything else
  function automatic sle_color_t pass_lamp(input logic ok);
    return ok ? SLE_GREEN : SLE_RED;
  endfunction

  // Only the two defined framing codes count as framed; the spare code
  // behaves as unframed so the framing lamp and receive alarm agree
  function automatic logic is_framed(input logic [1:0] mode);
    return (mode == SLE_ESF) || (mode == SLE_SF);
  endfunction

  function automatic sle_color_t frame_lamp(input logic [1:0] mode);
    sle_color_t colour;
    case (mode)
      SLE_ESF: begin
        colour = SLE_YELLOW; // see RULE_08
      end
      SLE_SF: begin
        colour = SLE_GREEN; // see RULE_08
      end
      // Unframed and the spare code leave the lamp dark
      default: begin
        colour = SLE_OFF; // see RULE_08
      end
    endcase
    return colour;
  endfunction

  // Local loss is tested first so it wins when both directions are lost
  function automatic sle_color_t alarm_lamp(input logic present,
    input logic far_loss);
    sle_color_t colour;
    colour = SLE_OFF;
    if (!present) begin
      colour = SLE_RED; // see RULE_06, see RULE_13
    end else if (far_loss) begin
      colour = SLE_YELLOW; // see RULE_06
    end
    return colour;
  endfunction

  // A local loopback outranks the far-end indication, so a technician at
  // the remote unit always sees its own loopback first
  function automatic sle_color_t loopback_lamp(input logic local_on,
    input logic far_on);
    sle_color_t colour;
    colour = SLE_OFF;
    if (local_on) begin
      colour = SLE_YELLOW; // see RULE_10
    end else if (far_on) begin
      colour = SLE_GREEN; // see RULE_11
    end
    return colour;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Loop verdicts from the two span receivers
  sle_loop_judge u_judge1 (
    .sync(loop1_sync),
    .errored(loop1_err),
    .margin_q(loop1_margin),
    .healthy(loop1_ok)
  );

  sle_loop_judge u_judge2 (
    .sync(loop2_sync),
    .errored(loop2_err),
    .margin_q(loop2_margin),
    .healthy(loop2_ok)
  );

  assign span_ok = loop1_ok && loop2_ok; // see RULE_04
  assign framed = is_framed(framing_mode);
  // Framed service alarms on lost framing, unframed on lost signal
  assign rx_loss = framed ? t1_frame_loss : !t1_present; // see RULE_07
  // Local loopbacks of either kind, or the far end's span loopback seen
  // only by the remote unit
  assign local_held = net_loopback || cust_loopback;
  assign far_held = !is_central && central_span_loopback;

  ////////////////////////////////////////////////////////////////////////////
  // Central unit shows the combined span verdict on both loop lamps
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      loop_one_led <= SLE_LAMP_RST;
    end else if (is_central) begin
      loop_one_led <= pass_lamp(span_ok); // see RULE_04
    end else begin
      loop_one_led <= pass_lamp(loop1_ok); // see RULE_01, see RULE_02
    end
  end

  // On the remote unit each lamp judges its own loop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      loop_two_led <= SLE_LAMP_RST;
    end else if (is_central) begin
      loop_two_led <= pass_lamp(span_ok); // see RULE_04
    end else begin
      loop_two_led <= pass_lamp(loop2_ok); // see RULE_03
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // A present signal with any error still shows red
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      t1_signal_led <= SLE_LAMP_RST;
    end else begin
      t1_signal_led <= pass_lamp(t1_present && !t1_err); // see RULE_05
    end
  end

  // Both loss inputs are levels; the lamp follows them one edge late
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_led <= SLE_LAMP_RST;
    end else begin
      alarm_led <= alarm_lamp(t1_present, t1_remote_loss); // see RULE_06
    end
  end

  // Receive alarm lamp only exists on the central unit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_alarm_led <= SLE_LAMP_RST;
    end else if (is_central && rx_loss) begin
      rx_alarm_led <= SLE_RED; // see RULE_07
    end else begin
      // The remote unit keeps this lamp dark
      rx_alarm_led <= SLE_OFF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Provisioning lamps track the settings every cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      framing_led <= SLE_LAMP_RST;
    end else begin
      framing_led <= frame_lamp(framing_mode); // see RULE_08
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      line_code_led <= SLE_LAMP_RST;
    end else begin
      line_code_led <= b8zs_mode ? SLE_YELLOW : SLE_GREEN; // see RULE_09
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      remote_loopback_led <= SLE_LAMP_RST;
    end else begin
      remote_loopback_led <= loopback_lamp(local_held, far_held);
    end
  end

  // All-ones toward the network hides the looped customer data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      send_ais <= 1'b0;
    end else begin
      send_ais <= is_central && cust_loopback; // see RULE_12
    end
  end

endmodule // sle_span_status_led

/* File: dv/sle_panel.sv */
`timescale 1ns/100ps
// Technician's eye: a lamp colour as seen one edge late
module sle_panel
  import sle_pkg::*;
(
  input wire logic mclk,
  input wire logic [1:0] lamp,
  output sle_color_t seen
);
  always_ff @(posedge mclk) begin
    seen <= sle_color_t'(lamp);
  end
endmodule // sle_panel

/* File: dv/sle_props.sv */
`timescale 1ns/100ps
module sle_props
  import sle_pkg::*;
(
  input wire logic mclk, rst_n, is_central, loop1_sync, loop1_err,
  input wire logic loop2_sync, loop2_err, t1_present, t1_err, b8zs_mode,
  input wire logic t1_frame_loss, t1_remote_loss, net_loopback,
  input wire logic cust_loopback, central_span_loopback, send_ais,
  input wire logic [7:0] loop1_margin, loop2_margin,
  input wire logic [1:0] framing_mode, loop_one_led, loop_two_led,
  input wire logic [1:0] t1_signal_led, alarm_led, rx_alarm_led,
  input wire logic [1:0] framing_led, line_code_led, remote_loopback_led
);
  logic v_q;
  wire ok1 = loop1_sync && !loop1_err && loop1_margin >= SLE_MARGIN_MIN_Q;
  wire ok2 = loop2_sync && !loop2_err && loop2_margin >= SLE_MARGIN_MIN_Q;
  wire fr = framing_mode == SLE_ESF || framing_mode == SLE_SF;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // $past still sees reset-time inputs on the first edge after release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      v_q <= 1'b0;
    end else begin
      v_q <= 1'b1;
    end
  end
  a_loop_one: assert property (v_q |-> loop_one_led ==
    ($past(ok1 && (ok2 || !is_central)) ? SLE_GREEN : SLE_RED))
    else $error("loop one lamp wrong");
  a_loop_two: assert property (v_q |-> loop_two_led ==
    ($past(ok2 && (ok1 || !is_central)) ? SLE_GREEN : SLE_RED))
    else $error("loop two lamp wrong");
  a_t1_lamp: assert property (v_q |-> t1_signal_led ==
    ($past(t1_present && !t1_err) ? SLE_GREEN : SLE_RED))
    else $error("signal lamp wrong");
  a_alarm_prio: assert property (v_q |-> alarm_led ==
    ($past(!t1_present) ? SLE_RED :
    $past(t1_remote_loss) ? SLE_YELLOW : SLE_OFF))
    else $error("alarm lamp wrong");
  a_rx_alarm: assert property (v_q |-> rx_alarm_led ==
    ($past(is_central && (fr ? t1_frame_loss : !t1_present)) ?
    SLE_RED : SLE_OFF)) else $error("receive alarm lamp wrong");
  a_frame_lamp: assert property (v_q |-> framing_led ==
    ($past(framing_mode) == SLE_ESF ? SLE_YELLOW :
    $past(framing_mode) == SLE_SF ? SLE_GREEN : SLE_OFF))
    else $error("framing lamp wrong");
  a_code_lamp: assert property (v_q |-> line_code_led ==
    ($past(b8zs_mode) ? SLE_YELLOW : SLE_GREEN))
    else $error("line code lamp wrong");
  a_lbk_lamp: assert property (v_q |->
    remote_loopback_led == ($past(net_loopback || cust_loopback) ?
    SLE_YELLOW : $past(!is_central && central_span_loopback) ?
    SLE_GREEN : SLE_OFF)) else $error("loopback lamp wrong");
  a_ais_send: assert property (v_q |->
    send_ais == $past(is_central && cust_loopback))
    else $error("all-ones request wrong");
endmodule // sle_props
bind sle_span_status_led sle_props u_sle_props (.mclk, .rst_n, .is_central,
  .loop1_sync, .loop1_err, .loop1_margin, .loop2_sync, .loop2_err,
  .loop2_margin, .t1_present, .t1_err, .t1_frame_loss, .t1_remote_loss,
  .framing_mode, .b8zs_mode, .net_loopback, .cust_loopback,
  .central_span_loopback, .loop_one_led, .loop_two_led, .t1_signal_led,
  .alarm_led, .rx_alarm_led, .framing_led, .line_code_led,
  .remote_loopback_led, .send_ais);

/* File: dv/tb_sle_span_status_led.sv */
`timescale 1ns/100ps
module tb_sle_span_status_led
  import sle_pkg::*;
();
  logic mclk = 0, rst_n = 0, is_central = 0, loop1_sync = 1, loop1_err = 0;
  logic loop2_sync = 1, loop2_err = 0, t1_present = 1, t1_err = 0;
  logic t1_frame_loss = 0, t1_remote_loss = 0, b8zs_mode = 0;
  logic net_loopback = 0, cust_loopback = 0, central_span_loopback = 0;
  logic [7:0] loop1_margin = 8'h0c, loop2_margin = 8'h0c;
  logic [1:0] framing_mode = 2'h0, loop_one_led, loop_two_led;
  logic [1:0] t1_signal_led, alarm_led, rx_alarm_led, framing_led;
  logic [1:0] line_code_led, remote_loopback_led;
  logic send_ais;
  sle_color_t seen;
  int errors = 0, n_compared = 0;
  always #10 mclk = ~mclk;
  sle_span_status_led u_sle_span_status_led (.mclk, .rst_n, .is_central,
    .loop1_sync, .loop1_err, .loop1_margin, .loop2_sync, .loop2_err,
    .loop2_margin, .t1_present, .t1_err, .t1_frame_loss, .t1_remote_loss,
    .framing_mode, .b8zs_mode, .net_loopback, .cust_loopback,
    .central_span_loopback, .loop_one_led, .loop_two_led, .t1_signal_led,
    .alarm_led, .rx_alarm_led, .framing_led, .line_code_led,
    .remote_loopback_led, .send_ais);
  sle_panel u_sle_panel (.mclk, .lamp(remote_loopback_led), .seen);
  task automatic ck(input logic [1:0] g, input logic [1:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch %0t got %0d exp %0d", $time, g, e);
    end
  endtask
  // Outputs follow inputs one edge later
  task automatic go;
    @(posedge mclk);
    #1;
  endtask
  task automatic wrap_up;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    ck(alarm_led, SLE_OFF);
    rst_n <= 1;
    go;
    ck(loop_one_led, SLE_GREEN);
    ck(line_code_led, SLE_GREEN);
    ck(t1_signal_led, SLE_GREEN);
    ck(alarm_led, SLE_OFF);
    @(posedge mclk);
    loop1_margin <= 8'h0b;
    b8zs_mode <= 1;
    go;
    ck(loop_one_led, SLE_RED);
    ck(loop_two_led, SLE_GREEN);
    ck(line_code_led, SLE_YELLOW);
    @(posedge mclk);
    is_central <= 1;
    go;
    ck(loop_two_led, SLE_RED);
    @(posedge mclk);
    loop1_margin <= 8'h0c;
    t1_err <= 1;
    go;
    ck(loop_one_led, SLE_GREEN);
    ck(t1_signal_led, SLE_RED);
    @(posedge mclk);
    t1_present <= 0;
    t1_remote_loss <= 1;
    go;
    ck(alarm_led, SLE_RED);
    ck(rx_alarm_led, SLE_RED);
    @(posedge mclk);
    t1_present <= 1;
    t1_frame_loss <= 1;
    go;
    ck(alarm_led, SLE_YELLOW);
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk);
      framing_mode <= m[1:0];
      go;
      ck(framing_led, m == SLE_ESF ? SLE_YELLOW :
        m == SLE_SF ? SLE_GREEN : SLE_OFF);
      ck(rx_alarm_led, m == 1 || m == 2 ? SLE_RED : SLE_OFF);
    end
    @(posedge mclk);
    cust_loopback <= 1;
    go;
    ck(remote_loopback_led, SLE_YELLOW);
    ck(send_ais, 1);
    @(posedge mclk);
    is_central <= 0;
    cust_loopback <= 0;
    central_span_loopback <= 1;
    t1_present <= 0;
    go;
    ck(remote_loopback_led, SLE_GREEN);
    ck(send_ais, 0);
    ck(rx_alarm_led, SLE_OFF);
    ck(alarm_led, SLE_RED);
    go;
    ck(seen, SLE_GREEN);
    wrap_up;
  end
endmodule // tb_sle_span_status_led
